// ===== hdl/pct_pkg.sv
// constants for the prescaled capture timer
package pct_pkg;

  // register bus
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // register indices; byte address is four times the index
  localparam logic [14:0] IDX_LOW_MATCH_DATA  = 15'h7E14;
  localparam logic [14:0] IDX_HIGH_MATCH_DATA = 15'h7E15;
  localparam logic [14:0] IDX_TIMER_CONTROL   = 15'h7F16;
  localparam logic [14:0] IDX_PRESCALER_MODE  = 15'h7F17;

  // reset values
  localparam logic [7:0] RST_LOW_MATCH_DATA  = 8'h00;
  localparam logic [7:0] RST_HIGH_MATCH_DATA = 8'h00;
  localparam logic [7:0] RST_TIMER_CONTROL   = 8'h00;
  localparam logic [7:0] RST_PRESCALER_MODE  = 8'h00;

  // timer_control fields
  localparam int unsigned CTL_HIGH_COUNT_ENABLE = 7;
  localparam int unsigned CTL_HIGH_MATCH_FLAG   = 6;
  localparam int unsigned CTL_HIGH_IRQ_ENABLE   = 5;
  localparam int unsigned CTL_CLOCK_SELECT_HI   = 4;
  localparam int unsigned CTL_CLOCK_SELECT_LO   = 3;
  localparam int unsigned CTL_RUN               = 2;
  localparam int unsigned CTL_MAIN_MATCH_FLAG   = 1;
  localparam int unsigned CTL_MAIN_IRQ_ENABLE   = 0;

  // prescaler_mode_control fields
  localparam int unsigned PMC_READ_SELECT    = 7;
  localparam int unsigned PMC_LENGTH_SELECT  = 6;
  localparam int unsigned PMC_CAPTURE_ENABLE = 5;
  localparam int unsigned PMC_PRESCALE_HI    = 4;
  localparam int unsigned PMC_PRESCALE_LO    = 0;

  // count clock sources
  localparam logic [1:0] CLK_SYSTEM     = 2'h0;
  localparam logic [1:0] CLK_RC         = 2'h1;
  localparam logic [1:0] CLK_FIRST_OSC  = 2'h2;
  localparam logic [1:0] CLK_SECOND_OSC = 2'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pct_pkg

// ===== hdl/reload_counter.sv
// one 8-bit counter with its match buffer
`timescale 1ns/1ps
`default_nettype none
module reload_counter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       step,
  input  wire logic       to_zero,
  input  wire logic [7:0] reload,
  output logic      [7:0] count_q,
  output logic      [7:0] buffer_q
);
  import pct_pkg::*;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 8'h00;
    end else if (!run) begin
      count_q <= 8'h00;
    end else if (step) begin
      // plain increment wraps as the low byte overflow
      count_q <= to_zero ? 8'h00 : count_q + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_q <= 8'h00;
    end else if (!run) begin
      buffer_q <= reload;
    end else if (step && to_zero) begin
      // new period value only takes effect at zero
      buffer_q <= reload;
    end
  end

endmodule : reload_counter
`default_nettype wire

// ===== hdl/prescaled_capture_timer.sv
// prescaled 16-bit / dual 8-bit capture timer with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - low reload register, 8-bit, resets zero
// - high reload register, 8-bit, resets zero
// - high enable clear stops high counter in 8-bit mode
// - high flag set when high counter wraps (16-bit: only with high enable)
// - irq when high enable and flag
// - clock select picks prescaler count source
// - run clear stops timer at zero
// - main flag set when timer wraps
// - irq when main enable and flag
// - flags cleared only by writing zero
// - read select swaps reloads for captures
// - length select: two 8-bit or 16-bit
// - capture enable gates all captures
// - capture triggers per mode from flags
// - prescale period is field plus one
// - prescaler matches field, resets on match/stop
// - low on prescaler, high on overflow/sysclk
// - buffers reload at zero, follow when stopped
// - 16-bit match needs all sixteen bits
module prescaled_capture_timer (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [pct_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [pct_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [pct_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [pct_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         rc_osc_in,
  input  wire logic                         first_oscillator,
  input  wire logic                         second_oscillator,
  output logic                              timer_irq
);
  import pct_pkg::*;

  // register state
  logic [7:0]        low_reload_q;
  logic [7:0]        high_reload_q;
  logic [7:0]        control_q;
  logic [7:0]        pmc_q;
  logic [7:0]        low_capture_q;
  logic [7:0]        high_capture_q;

  // bus state
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic              ar_pend_q;
  logic [ADDR_W-1:0] araddr_q;
  logic              wr_fire;
  logic [14:0]       wr_idx;
  logic [14:0]       rd_idx;
  logic              wr_hit;
  logic              rd_hit;
  logic              wr_en;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_idx  = awaddr_q[ADDR_W-1:2];
  assign rd_idx  = araddr_q[ADDR_W-1:2];
  assign wr_hit  = (wr_idx == IDX_LOW_MATCH_DATA) || (wr_idx == IDX_HIGH_MATCH_DATA)
                || (wr_idx == IDX_TIMER_CONTROL) || (wr_idx == IDX_PRESCALER_MODE);
  assign rd_hit  = (rd_idx == IDX_LOW_MATCH_DATA) || (rd_idx == IDX_HIGH_MATCH_DATA)
                || (rd_idx == IDX_TIMER_CONTROL) || (rd_idx == IDX_PRESCALER_MODE);
  // only byte lane 0 carries register bits
  assign wr_en   = wr_fire && wr_hit && wlane_q;

  // write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      awaddr_q      <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q     <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_have_q     <= 1'b0;
    end else if (!aw_have_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q     <= 1'b0;
      wbyte_q      <= 8'h00;
      wlane_q      <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q     <= 1'b1;
      wbyte_q      <= s_axi_wdata[7:0];
      wlane_q      <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_have_q     <= 1'b0;
    end else if (!w_have_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_pend_q     <= 1'b0;
      araddr_q      <= '0;
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_pend_q     <= 1'b1;
      araddr_q      <= s_axi_araddr;
      s_axi_arready <= 1'b0;
    end else if (ar_pend_q) begin
      ar_pend_q     <= 1'b0;
    end else if (!s_axi_rvalid && !s_axi_arready) begin
      s_axi_arready <= 1'b1;
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      IDX_LOW_MATCH_DATA:
        rd_byte = pmc_q[PMC_READ_SELECT] ? low_capture_q : low_reload_q;
      IDX_HIGH_MATCH_DATA:
        rd_byte = pmc_q[PMC_READ_SELECT] ? high_capture_q : high_reload_q;
      IDX_TIMER_CONTROL:  rd_byte = control_q;
      IDX_PRESCALER_MODE: rd_byte = pmc_q;
      default:            rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_pend_q) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // count clock sources
  // pins are foreign: two stages, then a third for the edge
  logic [2:0] src_meta_q;
  logic [2:0] src_sync_q;
  logic [2:0] src_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_meta_q <= 3'h0;
      src_sync_q <= 3'h0;
      src_prev_q <= 3'h0;
    end else begin
      src_meta_q <= {second_oscillator, first_oscillator, rc_osc_in};
      src_sync_q <= src_meta_q;
      src_prev_q <= src_sync_q;
    end
  end

  logic [2:0] src_rise;
  logic [1:0] clock_select;
  logic       count_tick;
  assign src_rise     = src_sync_q & ~src_prev_q;
  assign clock_select = control_q[CTL_CLOCK_SELECT_HI:CTL_CLOCK_SELECT_LO];
  always_comb begin
    count_tick = 1'b0;
    unique case (clock_select)
      CLK_SYSTEM: count_tick = 1'b1;
      CLK_RC:     count_tick = src_rise[0];
      CLK_FIRST_OSC:  count_tick = src_rise[1];
      CLK_SECOND_OSC: count_tick = src_rise[2];
    endcase
  end

  // prescaler
  logic       run;
  logic       length_sel;
  logic [4:0] prescale_value;
  logic [4:0] pre_count_q;
  logic       pre_match;
  assign run            = control_q[CTL_RUN];
  assign length_sel     = pmc_q[PMC_LENGTH_SELECT];
  assign prescale_value = pmc_q[PMC_PRESCALE_HI:PMC_PRESCALE_LO];
  assign pre_match      = run && count_tick && (pre_count_q == prescale_value);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_count_q <= 5'h00;
    end else if (!run || pre_match) begin
      pre_count_q <= 5'h00;
    end else if (count_tick) begin
      pre_count_q <= pre_count_q + 5'h01;
    end
  end

  // low and high counters
  logic       high_run;
  logic       low_step;
  logic       high_step;
  logic       low_zero;
  logic       high_zero;
  logic       match16;
  logic       low_match8;
  logic       high_match8;
  logic [7:0] low_count;
  logic [7:0] high_count;
  logic [7:0] low_buf;
  logic [7:0] high_buf;

  // high enable runs the high counter only in 8-bit mode; in 16-bit mode it gates the high flag
  assign high_run    = length_sel ? control_q[CTL_HIGH_COUNT_ENABLE] : run;
  assign low_step    = pre_match;
  assign high_step   = length_sel ? high_run : (pre_match && (low_count == 8'hFF));
  assign match16     = !length_sel && pre_match
                    && ({high_count, low_count} == {high_buf, low_buf});
  assign low_match8  = length_sel && pre_match && (low_count == low_buf);
  assign high_match8 = length_sel && high_run && (high_count == high_buf);
  assign low_zero    = match16 || low_match8;
  assign high_zero   = match16 || high_match8;

  reload_counter low_ctr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (run),
    .step     (low_step || match16),
    .to_zero  (low_zero),
    .reload   (low_reload_q),
    .count_q  (low_count),
    .buffer_q (low_buf)
  );

  reload_counter high_ctr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (high_run),
    .step     (high_step || match16),
    .to_zero  (high_zero),
    .reload   (high_reload_q),
    .count_q  (high_count),
    .buffer_q (high_buf)
  );

  // flags
  logic main_set;
  logic high_set;
  logic main_flag_d;
  logic high_flag_d;
  logic main_rise;
  logic high_rise;
  assign main_set = match16 || low_match8;
  assign high_set = length_sel ? high_match8
                  : (match16 && control_q[CTL_HIGH_COUNT_ENABLE]);

  // hardware set beats a same-cycle software clear
  always_comb begin
    main_flag_d = control_q[CTL_MAIN_MATCH_FLAG];
    high_flag_d = control_q[CTL_HIGH_MATCH_FLAG];
    if (wr_en && (wr_idx == IDX_TIMER_CONTROL)) begin
      main_flag_d = wbyte_q[CTL_MAIN_MATCH_FLAG];
      high_flag_d = wbyte_q[CTL_HIGH_MATCH_FLAG];
    end
    if (main_set) begin
      main_flag_d = 1'b1;
    end
    if (high_set) begin
      high_flag_d = 1'b1;
    end
  end
  assign main_rise = main_flag_d && !control_q[CTL_MAIN_MATCH_FLAG];
  assign high_rise = high_flag_d && !control_q[CTL_HIGH_MATCH_FLAG];

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_reload_q <= RST_LOW_MATCH_DATA;
    end else if (wr_en && (wr_idx == IDX_LOW_MATCH_DATA)) begin
      low_reload_q <= wbyte_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_reload_q <= RST_HIGH_MATCH_DATA;
    end else if (wr_en && (wr_idx == IDX_HIGH_MATCH_DATA)) begin
      high_reload_q <= wbyte_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_q <= RST_TIMER_CONTROL;
    end else begin
      if (wr_en && (wr_idx == IDX_TIMER_CONTROL)) begin
        control_q <= wbyte_q;
      end
      control_q[CTL_MAIN_MATCH_FLAG] <= main_flag_d;
      control_q[CTL_HIGH_MATCH_FLAG] <= high_flag_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pmc_q <= RST_PRESCALER_MODE;
    end else if (wr_en && (wr_idx == IDX_PRESCALER_MODE)) begin
      pmc_q <= wbyte_q;
    end
  end

  // capture
  // holds until the next trigger; software should read it promptly
  logic cap_en;
  assign cap_en = pmc_q[PMC_CAPTURE_ENABLE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_capture_q <= 8'h00;
    end else if (cap_en && high_rise) begin
      low_capture_q <= low_count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_capture_q <= 8'h00;
    end else if (cap_en && (length_sel ? main_rise : high_rise)) begin
      high_capture_q <= high_count;
    end
  end

  // interrupt request level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= (control_q[CTL_HIGH_IRQ_ENABLE]
                    && control_q[CTL_HIGH_MATCH_FLAG])
                || (control_q[CTL_MAIN_IRQ_ENABLE]
                    && control_q[CTL_MAIN_MATCH_FLAG]);
    end
  end

endmodule : prescaled_capture_timer
`default_nettype wire

// ===== bench/prescaled_capture_timer_props.sv
// port-level assertions for the prescaled capture timer
`timescale 1ns/1ps
`default_nettype none
module pct_props (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [pct_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic                       timer_irq
);
  import pct_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("late write answer");
  property p_rd_answer; s_rd_taken |-> ##[2:3] s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("late read answer");
  property p_aw_busy; s_wr_taken |=> !s_axi_awready [*3]; endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("write taken while busy");
  property p_ar_busy; s_rd_taken |=> !s_axi_arready [*3]; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_byte_wide; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_byte_wide: assert property (p_byte_wide) else $error("upper read bits set");
  // flags only fall through a write, so the request only falls after one
  property p_irq_fall;
    $fell(timer_irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request fell by itself");
  property p_reset_quiet;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !timer_irq && !s_axi_awready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy at reset");
endmodule : pct_props

bind prescaled_capture_timer pct_props i_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_irq(timer_irq)
);
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the prescaled capture timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb;
  import pct_pkg::*;
  localparam logic [ADDR_W-1:0] A_LR  = {IDX_LOW_MATCH_DATA, 2'h0};
  localparam logic [ADDR_W-1:0] A_HR  = {IDX_HIGH_MATCH_DATA, 2'h0};
  localparam logic [ADDR_W-1:0] A_CTL = {IDX_TIMER_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] A_PMC = {IDX_PRESCALER_MODE, 2'h0};
  localparam logic [ADDR_W-1:0] A_BAD = 17'h00000;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0]        wstrb = 4'hF;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              rc_osc = 1'b0, first_osc = 1'b0, second_osc = 1'b0;
  logic [3:0]        osc_cnt = 4'h0;
  logic              awready, wready, bvalid, arready, rvalid, timer_irq;
  logic [1:0]        bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        bq[$];
  logic [33:0]       rq[$];
  logic [1:0]        b_exp;
  logic [33:0]       r_exp;
  int                n_fail = 0;
  int                comparisons = 0;
  int                seed = 93;

  prescaled_capture_timer i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rc_osc_in(rc_osc), .first_oscillator(first_osc), .second_oscillator(second_osc),
    .timer_irq(timer_irq)
  );

  always #2.5 aclk = ~aclk;
  // three count sources at periods of 4, 8 and 16 cycles
  always @(posedge aclk) begin
    osc_cnt <= osc_cnt + 4'h1;
    rc_osc <= osc_cnt[1];
    first_osc <= osc_cnt[2];
    second_osc <= osc_cnt[3];
  end

  always @(posedge aclk) begin
    if (bvalid && bready) begin
      b_exp = bq.pop_front();
      `CHK(bresp, b_exp)
    end
    if (rvalid && rready) begin
      r_exp = rq.pop_front();
      `CHK({rresp, rdata}, r_exp)
    end
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic guard(input int n);
    if (n > 3000) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : guard

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    bq.push_back(er);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    rq.push_back({er, 24'h000000, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // stop and clear, start with ctl, count cycles to the request
  task automatic timed(input logic [7:0] ctl, output int c);
    wr(A_CTL, 8'h00, RESP_OKAY);
    wr(A_CTL, ctl, RESP_OKAY);
    c = 0;
    while (timer_irq !== 1'b1) begin
      @(posedge aclk);
      c++;
      guard(c);
    end
  endtask : timed

  initial begin
    int         ref_c, c, c2, lr, pr, per;
    logic [7:0] v;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_LR, 8'h00, RESP_OKAY);
    rd(A_HR, 8'h00, RESP_OKAY);
    rd(A_CTL, 8'h00, RESP_OKAY);
    rd(A_PMC, 8'h00, RESP_OKAY);
    rd(A_BAD, 8'h00, RESP_SLVERR);
    wr(A_BAD, 8'h5A, RESP_SLVERR);
    repeat (4) begin
      v = $random(seed);
      wr(A_LR, v, RESP_OKAY);
      wr(A_HR, ~v, RESP_OKAY);
      rd(A_LR, v, RESP_OKAY);
      rd(A_HR, ~v, RESP_OKAY);
    end
    // lane 0 strobe low: answered, but the register keeps its value
    wstrb <= 4'hE;
    wr(A_LR, ~v, RESP_OKAY);
    wstrb <= 4'hF;
    rd(A_LR, v, RESP_OKAY);
    // flags set by software stay until written zero
    wr(A_CTL, 8'h43, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(A_CTL, 8'h43, RESP_OKAY);
    `CHK(timer_irq, 1'b1)
    wr(A_CTL, 8'h42, RESP_OKAY);
    `CHK(timer_irq, 1'b0)
    wr(A_CTL, 8'h62, RESP_OKAY);
    `CHK(timer_irq, 1'b1)
    wr(A_CTL, 8'h20, RESP_OKAY);
    `CHK(timer_irq, 1'b0)
    // periods are compared against a one-tick reference, so pipeline delay cancels
    wr(A_PMC, 8'h40, RESP_OKAY);
    wr(A_LR, 8'h00, RESP_OKAY);
    timed(8'h05, ref_c);
    repeat (4) begin
      lr = $random(seed) & 7;
      pr = $random(seed) & 3;
      wr(A_PMC, {3'h2, pr[4:0]}, RESP_OKAY);
      wr(A_LR, lr[7:0], RESP_OKAY);
      timed(8'h05, c);
      `CHK(c - ref_c, (lr + 1) * (pr + 1) - 1)
    end
    wr(A_PMC, 8'h00, RESP_OKAY);
    wr(A_LR, 8'h02, RESP_OKAY);
    wr(A_HR, 8'h01, RESP_OKAY);
    timed(8'h05, c);
    `CHK(c - ref_c, 258)
    wr(A_PMC, 8'h40, RESP_OKAY);
    wr(A_HR, 8'h03, RESP_OKAY);
    timed(8'hA0, c);
    wr(A_HR, 8'h09, RESP_OKAY);
    timed(8'hA0, c2);
    `CHK(c2 - c, 6)
    // slow sources: eight extra ticks, phase jitter of one source period
    for (int s = 1; s < 4; s++) begin
      per = 2 << s;
      wr(A_LR, 8'h01, RESP_OKAY);
      timed({3'h0, s[1:0], 3'h5}, c);
      wr(A_LR, 8'h09, RESP_OKAY);
      timed({3'h0, s[1:0], 3'h5}, c2);
      `CHK((c2 - c >= 7 * per) && (c2 - c <= 9 * per), 1'b1)
    end
    wr(A_PMC, 8'h00, RESP_OKAY);
    wr(A_LR, 8'h05, RESP_OKAY);
    wr(A_HR, 8'h01, RESP_OKAY);
    timed(8'hA4, c);
    wr(A_PMC, 8'h80, RESP_OKAY);
    rd(A_LR, 8'h00, RESP_OKAY);
    wr(A_PMC, 8'h20, RESP_OKAY);
    timed(8'hA4, c);
    wr(A_PMC, 8'hA0, RESP_OKAY);
    rd(A_LR, 8'h05, RESP_OKAY);
    rd(A_HR, 8'h01, RESP_OKAY);
    // 8-bit: high byte taken at the low wrap, low byte at the high wrap
    wr(A_PMC, 8'h60, RESP_OKAY);
    wr(A_LR, 8'h03, RESP_OKAY);
    wr(A_HR, 8'h05, RESP_OKAY);
    timed(8'hA4, c);
    wr(A_PMC, 8'hE0, RESP_OKAY);
    rd(A_LR, 8'h01, RESP_OKAY);
    rd(A_HR, 8'h03, RESP_OKAY);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
